//--- common/gdpi_pkg.sv
/*
  Package for the graphics DRAM power-up sequencer: pin bundle, command
  encodings, timing figures and the register map of the controller port.
  Assumes a 200 MHz core clock.
*/
package gdpi_pkg;

  // Core clock period in picoseconds
  localparam int CORE_CLK_PS = 5000;

  // Timing figures as printed, then derived cycle counts (least times round up)
  localparam int T_POWER_STABLE_US = 100;
  localparam int T_CLOCK_STABLE_US = 200;
  localparam int T_DLL_LOCK_CK = 20000;
  localparam int POWER_STABLE_CYC = (T_POWER_STABLE_US * 1000000 + CORE_CLK_PS - 1) / CORE_CLK_PS;
  localparam int CLOCK_STABLE_CYC = (T_CLOCK_STABLE_US * 1000000 + CORE_CLK_PS - 1) / CORE_CLK_PS;
  localparam int MIN_REFRESH_COUNT = 2;
  localparam int CMD_GAP_CYC = 8;

  // Bank address codes for the two mode register writes
  localparam logic [2:0] BANK_EXT_MODE = 3'h1;
  localparam logic [2:0] BANK_MODE = 3'h0;

  // Address bit that widens a precharge to every bank
  localparam int ALL_BANK_SELECT_BIT = 8;
  // Mode register field that resets the DLL
  localparam int DLL_RESET_BIT = 8;
  localparam logic [11:0] EXT_MODE_DLL_ON = 12'h000;

  // Controller register map (word addresses)
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MODE_VALUE = 4'h2;
  localparam logic [3:0] REG_EXT_MODE_VALUE = 4'h3;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_TERM_FULL_BIT = 1;
  localparam int CTRL_REFRESH_BIT = 2;
  localparam logic [11:0] MODE_RESET_VALUE = 12'h000;

  // Command codes {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    GDPI_CMD_DESELECT = 4'b1111,
    GDPI_CMD_NOP = 4'b0111,
    GDPI_CMD_PRECHARGE = 4'b0010,
    GDPI_CMD_REFRESH = 4'b0001,
    GDPI_CMD_MODE_WRITE = 4'b0000
  } gdpi_cmd_t;

  // Pin bundle toward the memory device
  typedef struct packed {
    logic reset_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank;
    logic [11:0] addr;
  } gdpi_pins_t;

endpackage : gdpi_pkg

//--- src/gdpi_seq.sv
/*
  Power-up and initialisation sequencer for a graphics DRAM, host side.
  Software starts it through a small register port; the sequence runs in
  the link clock domain and drives reset, clock enable and commands.
  Assumes link_clk is the memory clock and that power is applied when
  core reset releases.
*/
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module gdpi_seq #(
  parameter int POWER_CYC = gdpi_pkg::POWER_STABLE_CYC,
  parameter int CLOCK_CYC = gdpi_pkg::CLOCK_STABLE_CYC,
  parameter int DLL_LOCK_CYC = gdpi_pkg::T_DLL_LOCK_CK,
  parameter int REFRESH_COUNT = gdpi_pkg::MIN_REFRESH_COUNT
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Link clock and its reset
  input wire logic link_clk,
  input wire logic link_srst,
  // Device pins
  output gdpi_pkg::gdpi_pins_t mem_pins,
  // Normal traffic gate
  output logic init_ready
);

  localparam int TW = 24;

  initial begin
    if (POWER_CYC < 1 || CLOCK_CYC < 1 || DLL_LOCK_CYC < 1) $error("gdpi_seq: bad wait");
    if (POWER_CYC >= (1 << TW) || CLOCK_CYC >= (1 << TW) || DLL_LOCK_CYC >= (1 << TW))
      $error("gdpi_seq: wait exceeds timer");
    if (REFRESH_COUNT < 2 || REFRESH_COUNT > 15) $error("gdpi_seq: bad refresh count");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_POWER, S_CLOCK, S_NOP, S_PRE1, S_EXTENDED_MODE_REGISTER_WRITE, S_MRS, S_PRE2,
    S_REF, S_LOCK, S_DONE
  } gdpi_state_t;

  // Core side control registers
  logic start_toggle;
  logic term_full;
  logic [11:0] mode_value;
  logic [11:0] ext_mode_value;

  // Link side state
  gdpi_state_t state;
  logic start_seen;
  logic [3:0] refresh_done;
  logic gap_busy;
  logic [3:0] gap_cnt;
  logic timer_load;
  logic [TW-1:0] timer_count;
  logic timer_busy;
  logic timer_done;
  logic ready_link;
  logic dll_locked_link;

  // Crossings
  logic start_sync;
  logic ready_core;
  logic locked_core;
  logic term_sync;

  // Build a command word on the pins
  function automatic gdpi_pkg::gdpi_pins_t make_cmd(input gdpi_pkg::gdpi_cmd_t cmd,
      input logic [2:0] bank, input logic [11:0] addr);
    gdpi_pkg::gdpi_pins_t p;
    p = '0;
    p.reset_n = 1'b1;
    p.cke = 1'b1;
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = cmd;
    p.bank = bank;
    p.addr = addr;
    return p;
  endfunction

  // Register writes; start is a toggle so the link domain sees one event
  always_ff @(posedge core_clk) begin
    if (srst) begin
      start_toggle <= 1'b0;
      term_full <= 1'b0;
      mode_value <= gdpi_pkg::MODE_RESET_VALUE;
      ext_mode_value <= gdpi_pkg::EXT_MODE_DLL_ON;
    end else if (reg_write) begin
      unique case (reg_addr)
        gdpi_pkg::REG_CONTROL: begin
          term_full <= reg_wdata[gdpi_pkg::CTRL_TERM_FULL_BIT];
          if (reg_wdata[gdpi_pkg::CTRL_START_BIT])
            start_toggle <= ~start_toggle;
        end
        gdpi_pkg::REG_MODE_VALUE: mode_value <= reg_wdata[11:0];
        gdpi_pkg::REG_EXT_MODE_VALUE: ext_mode_value <= reg_wdata[11:0];
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        gdpi_pkg::REG_CONTROL: reg_rdata <= {30'h0000_0000, term_full, 1'b0};
        gdpi_pkg::REG_STATUS: reg_rdata <= {30'h0000_0000, locked_core, ready_core};
        gdpi_pkg::REG_MODE_VALUE: reg_rdata <= {20'h0_0000, mode_value};
        gdpi_pkg::REG_EXT_MODE_VALUE: reg_rdata <= {20'h0_0000, ext_mode_value};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Start event into the link domain
  gdpi_sync u_start_sync (
    .clk(link_clk),
    .srst(link_srst),
    .din(start_toggle),
    .dout(start_sync)
  );

  // Termination choice is a quasi-static level
  gdpi_sync u_term_sync (
    .clk(link_clk),
    .srst(link_srst),
    .din(term_full),
    .dout(term_sync)
  );

  // Status back to the core domain
  gdpi_sync u_ready_sync (
    .clk(core_clk),
    .srst(srst),
    .din(ready_link),
    .dout(ready_core)
  );

  gdpi_sync u_lock_sync (
    .clk(core_clk),
    .srst(srst),
    .din(dll_locked_link),
    .dout(locked_core)
  );

  assign init_ready = ready_core;

  // Long waits on the link clock
  gdpi_timer #(
    .WIDTH(TW)
  ) u_timer (
    .clk(link_clk),
    .srst(link_srst),
    .load(timer_load),
    .count(timer_count),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Spacing between commands gives the device its mode write recovery
  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      gap_cnt <= '0;
      gap_busy <= 1'b0;
    end else if (state inside {S_NOP, S_PRE1, S_EXTENDED_MODE_REGISTER_WRITE, S_MRS, S_PRE2, S_REF} && !gap_busy) begin
      gap_cnt <= 4'(gdpi_pkg::CMD_GAP_CYC - 1);
      gap_busy <= 1'b1;
    end else if (gap_busy) begin
      gap_cnt <= gap_cnt - 4'h1;
      gap_busy <= (gap_cnt != 4'h0);
    end
  end

  // Sequencer; a command goes out once, then idles as nop until the gap ends
  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      state <= S_IDLE;
      start_seen <= 1'b0;
      refresh_done <= '0;
      timer_load <= 1'b0;
      timer_count <= '0;
      ready_link <= 1'b0;
      dll_locked_link <= 1'b0;
      mem_pins <= '0;
      mem_pins.cs_n <= 1'b1;
    end else begin
      start_seen <= start_sync;
      timer_load <= 1'b0;
      unique case (state)
        S_IDLE: begin
          mem_pins.reset_n <= 1'b0;
          mem_pins.cke <= 1'b0;
          mem_pins.cs_n <= 1'b1;
          if (start_sync != start_seen) begin
            ready_link <= 1'b0;
            dll_locked_link <= 1'b0;
            timer_count <= TW'(POWER_CYC);
            timer_load <= 1'b1;
            state <= S_POWER;
          end
        end
        S_POWER: begin
          mem_pins.cke <= term_sync;
          if (timer_done) begin
            mem_pins.reset_n <= 1'b1;
            timer_count <= TW'(CLOCK_CYC);
            timer_load <= 1'b1;
            state <= S_CLOCK;
          end
        end
        S_CLOCK: begin
          mem_pins <= make_cmd(gdpi_pkg::GDPI_CMD_DESELECT, '0, '0);
          if (timer_done && !timer_load)
            state <= S_NOP;
        end
        S_NOP: begin
          mem_pins <= make_cmd(gdpi_pkg::GDPI_CMD_NOP, '0, '0);
          if (gap_busy && gap_cnt == 4'h0)
            state <= S_PRE1;
        end
        S_PRE1, S_PRE2: begin
          mem_pins <= gap_busy ? make_cmd(gdpi_pkg::GDPI_CMD_NOP, '0, '0)
            : make_cmd(gdpi_pkg::GDPI_CMD_PRECHARGE, '0,
                12'(1 << gdpi_pkg::ALL_BANK_SELECT_BIT));
          if (gap_busy && gap_cnt == 4'h0)
            state <= (state == S_PRE1) ? S_EXTENDED_MODE_REGISTER_WRITE : S_REF;
        end
        S_EXTENDED_MODE_REGISTER_WRITE: begin
          mem_pins <= gap_busy ? make_cmd(gdpi_pkg::GDPI_CMD_NOP, '0, '0)
            : make_cmd(gdpi_pkg::GDPI_CMD_MODE_WRITE, gdpi_pkg::BANK_EXT_MODE,
                ext_mode_value);
          if (gap_busy && gap_cnt == 4'h0)
            state <= S_MRS;
        end
        S_MRS: begin
          mem_pins <= gap_busy ? make_cmd(gdpi_pkg::GDPI_CMD_NOP, '0, '0)
            : make_cmd(gdpi_pkg::GDPI_CMD_MODE_WRITE, gdpi_pkg::BANK_MODE,
                mode_value | 12'(1 << gdpi_pkg::DLL_RESET_BIT));
          if (!gap_busy) begin
            timer_count <= TW'(DLL_LOCK_CYC);
            timer_load <= 1'b1;
          end
          if (gap_busy && gap_cnt == 4'h0)
            state <= S_PRE2;
        end
        S_REF: begin
          mem_pins <= gap_busy ? make_cmd(gdpi_pkg::GDPI_CMD_NOP, '0, '0)
            : make_cmd(gdpi_pkg::GDPI_CMD_REFRESH, '0, '0);
          if (!gap_busy)
            refresh_done <= refresh_done + 4'h1;
          if (gap_busy && gap_cnt == 4'h0 && refresh_done == 4'(REFRESH_COUNT))
            state <= S_LOCK;
        end
        S_LOCK: begin
          mem_pins <= make_cmd(gdpi_pkg::GDPI_CMD_NOP, '0, '0);
          ready_link <= 1'b1;
          if (!timer_busy) begin
            dll_locked_link <= 1'b1;
            state <= S_DONE;
          end
        end
        S_DONE: begin
          mem_pins <= make_cmd(gdpi_pkg::GDPI_CMD_DESELECT, '0, '0);
          if (start_sync != start_seen) begin
            // Device goes back into reset, so normal traffic is blocked again
            ready_link <= 1'b0;
            dll_locked_link <= 1'b0;
            refresh_done <= '0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // gdpi_seq
`default_nettype wire

//--- src/gdpi_sync.sv
/*
  Two-stage synchroniser for a single level.
  Assumes the input is unrelated in phase to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module gdpi_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Level in and out
  input wire logic din,
  output logic dout
);

  logic stage1;

  // Only the second stage reads the first
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // gdpi_sync
`default_nettype wire

//--- src/gdpi_timer.sv
/*
  Down-counting wait timer: load a count, done pulses once when it expires.
  Assumes load is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module gdpi_timer #(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  // Status
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] remain;

  initial begin
    if (WIDTH < 2) $error("gdpi_timer: WIDTH too small");
  end

  // Count down, flag the last step
  always_ff @(posedge clk) begin
    if (srst) begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      remain <= count;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      done <= (remain <= WIDTH'(1));
      busy <= (remain > WIDTH'(1));
      remain <= remain - WIDTH'(1);
    end else begin
      done <= 1'b0;
    end
  end

endmodule // gdpi_timer
`default_nettype wire

//--- tb/gdpi_dram_model.sv
/* Behavioural model of the memory device during initialisation.
   Assumes the pins change only on link_clk. */
`timescale 1ns/10ps
`default_nettype none
module gdpi_dram_model (
  // Link clock and pins
  input wire logic link_clk,
  input wire gdpi_pkg::gdpi_pins_t pins,
  // Observed state
  output logic term_full,
  output logic [11:0] ext_val,
  output logic [11:0] mode_val,
  output var int refs,
  output var int errs,
  output var real mrs_t
);
  logic rst_q;
  logic dll_on;
  int step;
  // Decode only what a selected device out of reset would take
  always @(posedge link_clk) begin
    rst_q <= pins.reset_n;
    if (!pins.reset_n) begin
      step <= 0;
      refs <= 0;
      dll_on <= 1'b0;
    end else begin
      if (!rst_q)
        term_full <= pins.cke;
      if (!pins.cs_n) begin
        case ({pins.ras_n, pins.cas_n, pins.we_n})
          3'b010: begin
            if (!pins.addr[8] || (step != 0 && step != 3))
              errs <= errs + 1;
            step <= step + 1;
          end
          3'b000: begin
            if (step == 1 && pins.bank == gdpi_pkg::BANK_EXT_MODE) begin
              ext_val <= pins.addr;
              dll_on <= 1'b1;
            end else if (step == 2 && pins.bank == gdpi_pkg::BANK_MODE) begin
              mode_val <= pins.addr;
              mrs_t <= $realtime;
            end else
              errs <= errs + 1;
            step <= step + 1;
          end
          3'b001: begin
            if (step != 4 || !dll_on)
              errs <= errs + 1;
            refs <= refs + 1;
          end
          3'b111: ;
          default: errs <= errs + 1;
        endcase
      end
    end
  end
endmodule // gdpi_dram_model
`default_nettype wire

//--- tb/gdpi_seq_chk.sv
/* Pin checker for the power-up sequencer.
   Assumes binding to gdpi_seq; link_srst resets the link domain. */
`timescale 1ns/10ps
`default_nettype none
module gdpi_seq_chk #(parameter int POWER_CYC = 20) (
  // Core side
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic init_ready,
  // Link side
  input wire logic link_clk,
  input wire logic link_srst,
  input wire gdpi_pkg::gdpi_pins_t mem_pins
);
  // Command decode of the pins
  wire logic [3:0] cmd = {mem_pins.cs_n, mem_pins.ras_n, mem_pins.cas_n, mem_pins.we_n};
  wire logic is_pre = cmd == gdpi_pkg::GDPI_CMD_PRECHARGE;
  wire logic is_mw = cmd == gdpi_pkg::GDPI_CMD_MODE_WRITE;
  wire logic is_ref = cmd == gdpi_pkg::GDPI_CMD_REFRESH;
  wire logic is_nop = cmd == gdpi_pkg::GDPI_CMD_NOP;
  int low_cnt;
  // Cycles in reset, saturated so a long idle cannot wrap
  always_ff @(posedge link_clk) begin
    if (link_srst || mem_pins.reset_n)
      low_cnt <= 0;
    else if (low_cnt < 100000)
      low_cnt <= low_cnt + 1;
  end
  default clocking @(posedge link_clk); endclocking
  default disable iff (link_srst);
  // Steps of the init chain
  sequence ext_s;
    is_mw && mem_pins.bank == gdpi_pkg::BANK_EXT_MODE;
  endsequence
  sequence dll_rst_s;
    is_mw && mem_pins.bank == gdpi_pkg::BANK_MODE && mem_pins.addr[8];
  endsequence
  // Commands land nine link cycles apart: one command, then eight nops
  sequence two_ref_s;
    ##9 is_ref ##9 is_ref;
  endsequence
  reset_quiet_a: assert property (!mem_pins.reset_n |-> mem_pins.cs_n) else $error("cs low");
  cmd_awake_a: assert property (!mem_pins.cs_n |-> mem_pins.reset_n && mem_pins.cke) else $error("cke");
  deselect_wait_a: assert property ($rose(mem_pins.reset_n) |-> mem_pins.cs_n [*8]) else $error("early");
  power_wait_a: assert property ($rose(mem_pins.reset_n) |-> low_cnt >= POWER_CYC) else $error("short");
  all_banks_a: assert property (is_pre |-> mem_pins.addr[8]) else $error("one bank");
  nop_first_a: assert property (is_pre && !$past(is_mw, 9) |-> $past(is_nop)) else $error("nop");
  dll_on_a: assert property (ext_s |-> $past(is_pre, 9)) else $error("ext order");
  dll_reset_a: assert property (ext_s |-> ##9 dll_rst_s) else $error("mode order");
  pre_again_a: assert property (dll_rst_s |-> ##9 is_pre) else $error("pre order");
  two_ref_a: assert property (is_pre && $past(is_mw, 9) |-> two_ref_s) else $error("refresh");
endmodule // gdpi_seq_chk
bind gdpi_seq gdpi_seq_chk #(.POWER_CYC(POWER_CYC)) u_chk (
  .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .init_ready(init_ready),
  .link_clk(link_clk), .link_srst(link_srst), .mem_pins(mem_pins));
`default_nettype wire

//--- tb/gdpi_seq_tb.sv
/* Self-checking bench for the power-up sequencer.
   Assumes the device model on the pins and shortened waits. */
`timescale 1ns/10ps
`default_nettype none
module gdpi_seq_tb;
  localparam int DLL_SIM = 50;
  logic core_clk = 0;
  logic srst = 1;
  logic link_clk = 0;
  logic link_srst = 1;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_write = 0;
  logic reg_read = 0;
  logic rd_d = 0;
  logic [31:0] reg_rdata;
  logic init_ready;
  logic term_full;
  logic [11:0] ext_val, mode_val, ev, mv;
  gdpi_pkg::gdpi_pins_t mem_pins;
  int refs, errs;
  real mrs_t;
  int error_cnt = 0;
  int comparisons = 0;
  logic [31:0] exp_q[$];
  // Core clock
  always #2.5 core_clk = ~core_clk;
  // Link clock with an odd phase offset
  initial begin
    #1.3;
    forever #6 link_clk = ~link_clk;
  end
  gdpi_seq #(.POWER_CYC(20), .CLOCK_CYC(20), .DLL_LOCK_CYC(DLL_SIM), .REFRESH_COUNT(2)) DUT (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .link_srst(link_srst), .mem_pins(mem_pins), .init_ready(init_ready));
  gdpi_dram_model u_mem (.link_clk(link_clk), .pins(mem_pins), .term_full(term_full),
    .ext_val(ext_val), .mode_val(mode_val), .refs(refs), .errs(errs), .mrs_t(mrs_t));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_read <= 1'b0;
  endtask
  // Read data counts only in the cycle after the strobe
  always @(posedge core_clk) begin
    rd_d <= reg_read;
    if (rd_d)
      check("reg_rdata", reg_rdata, exp_q.pop_front());
  end
  task automatic wait_ready(input logic lvl);
    int i;
    for (i = 0; i < 4000 && init_ready !== lvl; i++)
      @(posedge core_clk);
    check("init_ready", 32'(init_ready), 32'(lvl));
  endtask
  // One full init; optionally a second start while it runs
  task automatic run(input logic term, input logic again);
    ev = 12'($urandom);
    mv = 12'($urandom);
    wr(gdpi_pkg::REG_EXT_MODE_VALUE, {20'h0, ev});
    rd(gdpi_pkg::REG_EXT_MODE_VALUE, {20'h0, ev});
    wr(gdpi_pkg::REG_MODE_VALUE, {20'h0, mv});
    wr(gdpi_pkg::REG_CONTROL, (32'(term) << gdpi_pkg::CTRL_TERM_FULL_BIT) | 32'h1);
    if (again) begin
      repeat (100) @(posedge core_clk);
      wr(gdpi_pkg::REG_CONTROL, 32'h1);
    end
    wait_ready(1'b1);
    check("term", 32'(term_full), 32'(term));
    check("ext", 32'(ext_val), 32'(ev));
    check("mode", 32'(mode_val), 32'(mv | 12'h100));
    check("order", 32'(errs), 32'h0);
    check("refs", 32'(refs >= 2), 32'h1);
    // Lock must not show before the lock wait after the mode write is over
    while ($realtime < mrs_t + (DLL_SIM - 2) * 12.0)
      @(posedge core_clk);
    rd(gdpi_pkg::REG_STATUS, 32'h1);
    repeat (DLL_SIM) @(posedge core_clk);
    check("dll", 32'(($realtime - mrs_t) >= DLL_SIM * 12.0), 32'h1);
    rd(gdpi_pkg::REG_STATUS, 32'h3);
  endtask
  initial begin
    void'($urandom(32'h1dd7_73a6));
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge link_clk);
    link_srst <= 1'b0;
    rd(gdpi_pkg::REG_STATUS, 32'h0);
    rd(4'h9, 32'h0);
    $display("test reset_values done");
    run(1'b1, 1'b0);
    $display("test full_term done");
    wr(gdpi_pkg::REG_CONTROL, 32'h1);
    wait_ready(1'b0);
    repeat (8) @(posedge core_clk);
    check("reset_n", 32'(mem_pins.reset_n), 32'h0);
    check("cs_n", 32'(mem_pins.cs_n), 32'h1);
    $display("test back_to_idle done");
    run(1'b0, 1'b1);
    $display("test half_term done");
    repeat (4) @(posedge core_clk);
    end_of_test();
  end
  // Hang guard
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule // gdpi_seq_tb
`default_nettype wire
